// File: design/mdmctl_top.v
/*
 * Modem control block: holds the modem control byte, drives data
 * terminal ready, select frequency and polling, and keeps the
 * half-duplex transmit/receive interlock.
 * Assumes all inputs synchronous to CLK; the mode definition engine
 * presents line characteristics with a one-cycle strobe.
 */
`include "mdmctl_regs.vh"

module mdmctl_top (
	input wire CLK,
	input wire RST_N,
	input wire CTL_WR,
	input wire [7:0] CTL_WDATA,
	output reg [7:0] CTL_RDATA,
	output reg [7:0] STS_RDATA,
	input wire MODE_DEF,
	input wire MODE_HALFDPX,
	input wire MODE_CHAROP,
	input wire DTR_REQ,
	input wire SELFREQ_REQ,
	input wire MULTIPOINT,
	input wire POLL_REQ,
	input wire TX_ACTIVE,
	input wire RX_REQ,
	input wire RTS_REQ,
	input wire CTS,
	input wire TEST_IND,
	output reg DTR,
	output reg SELFREQ,
	output reg POLL,
	output reg RTS,
	output reg TX_EN,
	output reg RX_EN
);

	// ------------------------------------------------------
	// constants
	// ------------------------------------------------------
	// pulse length in core cycles, cut to the counter width on purpose
	localparam integer POLL_CYC_INT = `MDMCTL_POLL_CYC;
	localparam [`MDMCTL_POLL_W-1:0] POLL_CYC =
		POLL_CYC_INT[`MDMCTL_POLL_W-1:0];
	localparam [`MDMCTL_POLL_W-1:0] POLL_ZERO =
		{`MDMCTL_POLL_W{1'b0}};
	localparam [`MDMCTL_POLL_W-1:0] POLL_ONE =
		{{(`MDMCTL_POLL_W-1){1'b0}}, 1'b1};

	// poll sequencer states, one-hot
	localparam [1:0] ST_IDLE = 2'h1;
	localparam [1:0] ST_PULSE = 2'h2;

	// ------------------------------------------------------
	// control byte
	// ------------------------------------------------------
	reg standby;
	reg maint2;
	reg maint1;
	reg halfdpx;
	reg charop;
	reg next_standby;
	reg next_maint2;
	reg next_maint1;
	reg next_halfdpx;
	reg next_charop;

	// host writes and mode definition may share a cycle: they touch
	// disjoint bits, so neither can undo the other
	always @* begin
		next_standby = standby;
		next_maint2 = maint2;
		next_maint1 = maint1;
		next_halfdpx = halfdpx;
		next_charop = charop;
		if (CTL_WR) begin
			// half-duplex bit deliberately not taken
			next_standby = CTL_WDATA[`MDMCTL_CTL_STANDBY];
			next_maint2 = CTL_WDATA[`MDMCTL_CTL_MAINT2];
			next_maint1 = CTL_WDATA[`MDMCTL_CTL_MAINT1];
		end
		if (MODE_DEF) begin
			next_halfdpx = MODE_HALFDPX;
			next_charop = MODE_CHAROP;
		end
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			standby <= 1'h0;
			maint2 <= 1'h0;
			maint1 <= 1'h0;
			halfdpx <= 1'h0;
			charop <= `MDMCTL_STS_PROTO_RESET;
		end else begin
			standby <= next_standby;
			maint2 <= next_maint2;
			maint1 <= next_maint1;
			halfdpx <= next_halfdpx;
			charop <= next_charop;
		end
	end

	// ------------------------------------------------------
	// polling pulse
	// ------------------------------------------------------
	reg [1:0] poll_state;
	reg [1:0] next_poll_state;
	reg [`MDMCTL_POLL_W-1:0] poll_cnt;
	reg [`MDMCTL_POLL_W-1:0] next_poll_cnt;
	wire poll_start;

	// requests during a running pulse are dropped, not queued
	assign poll_start = POLL_REQ && MULTIPOINT && (poll_state == ST_IDLE);

	always @* begin
		next_poll_state = poll_state;
		next_poll_cnt = poll_cnt;
		case (poll_state)
		ST_IDLE: begin
			if (poll_start) begin
				next_poll_state = ST_PULSE;
				next_poll_cnt = POLL_CYC;
			end
		end
		ST_PULSE: begin
			next_poll_cnt = poll_cnt - POLL_ONE;
			if (poll_cnt == POLL_ONE) begin
				next_poll_state = ST_IDLE;
			end
		end
		default: begin
			next_poll_state = ST_IDLE;
			next_poll_cnt = POLL_ZERO;
		end
		endcase
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			poll_state <= ST_IDLE;
			poll_cnt <= POLL_ZERO;
		end else begin
			poll_state <= next_poll_state;
			poll_cnt <= next_poll_cnt;
		end
	end

	// ------------------------------------------------------
	// interlock
	// ------------------------------------------------------
	reg next_tx_en;
	reg next_rx_en;
	reg next_poll;

	always @* begin
		// data waits for clear to send on a raised request
		next_tx_en = RTS && CTS && TX_ACTIVE;
		// receiver stays shut while sending in half duplex
		next_rx_en = RX_REQ && !(halfdpx && TX_ACTIVE);
		// last count value ends the pulse, so it is exactly POLL_CYC
		next_poll = poll_start ||
			((poll_state == ST_PULSE) && (poll_cnt != POLL_ONE));
	end

	// ------------------------------------------------------
	// modem pins and read bytes
	// ------------------------------------------------------
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			DTR <= 1'h0;
			SELFREQ <= 1'h0;
			POLL <= 1'h0;
			RTS <= 1'h0;
			TX_EN <= 1'h0;
			RX_EN <= 1'h0;
			CTL_RDATA <= `MDMCTL_CTL_RESET;
			STS_RDATA <= {7'h00, `MDMCTL_STS_PROTO_RESET};
		end else begin
			DTR <= DTR_REQ;
			SELFREQ <= SELFREQ_REQ;
			POLL <= next_poll;
			RTS <= RTS_REQ;
			TX_EN <= next_tx_en;
			RX_EN <= next_rx_en;
			// unused control bits read as zero
			CTL_RDATA[0] <= 1'h0;
			CTL_RDATA[`MDMCTL_CTL_STANDBY] <= standby;
			CTL_RDATA[`MDMCTL_CTL_MAINT2] <= maint2;
			CTL_RDATA[`MDMCTL_CTL_MAINT1] <= maint1;
			CTL_RDATA[`MDMCTL_CTL_HALFDPX] <= halfdpx;
			CTL_RDATA[7:5] <= 3'h0;
			// unused status bits read as zero
			STS_RDATA[`MDMCTL_STS_PROTO] <= charop;
			STS_RDATA[1] <= 1'h0;
			STS_RDATA[`MDMCTL_STS_TEST] <= TEST_IND;
			STS_RDATA[7:3] <= 5'h00;
		end
	end

endmodule

// File: design/mdmctl_regs.vh
/*
 * Constants for the modem control block: byte field positions, reset
 * values and the polling pulse length.
 * Assumes a 250 MHz core clock and byte-wide register ports.
 */
`ifndef MDMCTL_REGS_VH
`define MDMCTL_REGS_VH

// --------------------------------------------------------------
// modem control write byte fields
// --------------------------------------------------------------
`define MDMCTL_CTL_STANDBY 1
`define MDMCTL_CTL_MAINT2 2
`define MDMCTL_CTL_MAINT1 3
`define MDMCTL_CTL_HALFDPX 4
`define MDMCTL_CTL_RESET 8'h00

// --------------------------------------------------------------
// modem status read byte fields
// --------------------------------------------------------------
`define MDMCTL_STS_PROTO 0
`define MDMCTL_STS_TEST 2
`define MDMCTL_STS_PROTO_RESET 1'b1

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define MDMCTL_CLK_MHZ 250
`define MDMCTL_POLL_NS 1000
`define MDMCTL_POLL_CYC ((`MDMCTL_POLL_NS * `MDMCTL_CLK_MHZ + 999) / 1000)
`define MDMCTL_POLL_W 10

`endif

// File: dv/mdmctl_sva.sv
/* checker of mdmctl_top ports; assumes bind by name */
module mdmctl_sva(input wire CLK,RST_N,MODE_DEF,TX_ACTIVE,RX_EN,CTS,TX_EN,
	MULTIPOINT,POLL_REQ,POLL,input wire [7:0] CTL_RDATA,STS_RDATA);
timeunit 1ns; timeprecision 1ns;
default clocking @(posedge CLK); endclocking
default disable iff (!RST_N);
sequence poll_run; ##249 POLL ##1 !POLL; endsequence
rst_val_a: assert property (!$past(RST_N) |-> CTL_RDATA==8'h00 &&
	STS_RDATA[0]) else $error("bad reset value");
hdx_hold_a: assert property ($changed(CTL_RDATA[4]) |->
	$past(MODE_DEF,2)||$past(MODE_DEF,3)) else $error("half duplex moved");
proto_hold_a: assert property ($changed(STS_RDATA[0]) |->
	$past(MODE_DEF,2)||$past(MODE_DEF,3)) else $error("protocol moved");
rx_lock_a: assert property (CTL_RDATA[4]&&$past(TX_ACTIVE) |-> !RX_EN)
	else $error("receive during transmit");
tx_gate_a: assert property (TX_EN |-> $past(CTS))
	else $error("transmit without clear");
poll_gate_a: assert property ($rose(POLL) |-> $past(MULTIPOINT&&POLL_REQ)
	||$past(MULTIPOINT&&POLL_REQ,2)) else $error("poll not asked");
poll_len_a: assert property ($rose(POLL) |-> poll_run)
	else $error("poll length");
endmodule
bind mdmctl_top mdmctl_sva i_mdmctl_sva(.*);

// File: dv/mdmctl_modem.sv
/* modem model: line hold, clear to send, bands, timing recovery;
   assumes CLK from the bench and device pins settled off negedge */
module mdmctl_modem(input wire CLK,RTS,DTR,SELFREQ,POLL,TX_EN,
	output logic CTS,TEST_IND);
timeunit 1ns; timeprecision 1ns;
logic online=0,high_band=0;
logic [3:0] lock=4'h0;
// stays on line until data already handed over is sent
always @(negedge CLK) online<=DTR||(online&&TX_EN);
// prompt answer, only while connected
always @(negedge CLK) CTS<=RTS&&online;
always @(negedge CLK) TEST_IND<=!DTR;
// set up to ignore select frequency: bands held fixed
always @(negedge CLK) high_band<=1'b0;
// timing recovery restarts while polling is up
always @(negedge CLK) lock<=POLL?4'h0:lock+{3'h0,lock!=4'hf};
endmodule

// File: dv/mdmctl_top_bench.sv
/* bench of mdmctl_top; assumes mdmctl_modem */
module mdmctl_top_bench;
timeunit 1ns; timeprecision 1ns;
logic c=0,r=0,w=0,md=0,mh=0,mc=0,mp=0,pq=0,ta=0,rq=1,rt=1,dq=1;
logic [7:0] wd=0,cr,sr;
logic ct,ti,po,te,re,rts,dtr,sf;
int err_total=0,check_count=0,n;
logic [15:0] rows[3]='{16'hff0e,16'h1000,16'h0a0a};
always #2 c=~c;
mdmctl_top i_mdmctl_top(.CLK(c),.RST_N(r),.CTL_WR(w),.CTL_WDATA(wd),
	.CTL_RDATA(cr),.STS_RDATA(sr),.MODE_DEF(md),.MODE_HALFDPX(mh),
	.MODE_CHAROP(mc),.DTR_REQ(dq),.SELFREQ_REQ(dq),.MULTIPOINT(mp),
	.POLL_REQ(pq),.TX_ACTIVE(ta),.RX_REQ(rq),.RTS_REQ(rt),.CTS(ct),
	.TEST_IND(ti),.DTR(dtr),.SELFREQ(sf),.POLL(po),.RTS(rts),.TX_EN(te),
	.RX_EN(re));
mdmctl_modem i_mdmctl_modem(.CLK(c),.RTS(rts),.DTR(dtr),.SELFREQ(sf),
	.POLL(po),.TX_EN(te),.CTS(ct),.TEST_IND(ti));
task cyc(input int k); repeat (k) @(negedge c); endtask
task chk(input logic [7:0] g,e);
	check_count++;
	if (g!==e) begin
		err_total++;
		$display("mismatch %0t got %h want %h",$time,g,e);
	end
endtask
task wr(input logic [7:0] d); wd=d; w=1; cyc(1); w=0; cyc(2); endtask
task final_report;
	$display("checks %0d errors %0d",check_count,err_total);
	if (err_total==0&&check_count>0) $display("Run complete: PASS");
	else $display("Run complete: FAIL");
	$finish;
endtask
initial begin
	cyc(2);
	r=1;
	chk(cr,8'h00);
	chk({7'h0,sr[0]},8'h01);
	foreach (rows[i]) begin
		wr(rows[i][15:8]);
		chk(cr,rows[i][7:0]);
	end
	chk({7'h0,dtr},8'h01);
	chk({7'h0,sf},8'h01);
	mh=1; md=1; cyc(1); md=0; cyc(2);
	chk(cr,8'h1a);
	chk({7'h0,sr[0]},8'h00);
	wr(8'h00);
	chk(cr,8'h10);
	ta=1; cyc(3);
	chk({7'h0,re},8'h00);
	chk({7'h0,te},8'h01);
	ta=0; cyc(3);
	chk({7'h0,re},8'h01);
	rt=0; ta=1; cyc(3);
	chk({7'h0,te},8'h00);
	chk({7'h0,re},8'h00);
	rt=1; ta=0; cyc(3);
	mp=1; pq=1; cyc(1); pq=0; n=0;
	while (po!==1'b1&&n<4) begin cyc(1); n++; end
	if (n==4) begin
		err_total++;
		$display("mismatch %0t poll never rose",$time);
	end
	n=0;
	while (po===1'b1&&n<300) begin cyc(1); n++; end
	chk(8'(n),8'hfa);
	mp=0; pq=1; cyc(3);
	chk({7'h0,po},8'h00);
	pq=0;
	mh=0; mc=1; md=1; cyc(1); md=0; cyc(2);
	chk(cr,8'h00);
	chk({7'h0,sr[0]},8'h01);
	ta=1; cyc(3);
	chk({7'h0,re},8'h01);
	ta=0; dq=0; cyc(3);
	chk({7'h0,dtr},8'h00);
	chk({7'h0,sf},8'h00);
	chk(sr,8'h05);
	final_report;
end
endmodule
